// ===== rtl/frame_copy_forwarder.v
// frame copy forwarder: arbitration, copy limiting, tail drop, copy table translation
//
// Summary of operation
// [R01] one frame taken per enabled clock; peak rate scales with the clock
// [R02] above a port's threshold, copies per frame are capped, extra copies dropped
// [R03] any ingress queue above its watermark sets the chip-wide harsh state
// [R04] harsh state drops unflowcontrolled copies over pause level with egress reserve gone
// [R05] harsh discarding only applies to ports whose harsh enable bit is set
// [R06] each port's ingress queue size is readable status
// [R07] one shared counter sums forward-pressure drops over all ports
// [R08] destination set bit per front port gives one normal switched copy
// [R09] cpu queue, mirror and learn bits go through a 12-entry copy table
// [R10] eight cpu queues each map to a cpu port or a front port
// [R11] cpu copy qos follows ingress, is fixed, or is super priority
// [R12] three mirror probes, each with its own egress port and qos
// [R13] learn-all copies go to first, second or both stacking links
// [R14] a configurable extra egress port also gets learn-all copies
// [R15] per port: forwarding enable, speed setting and drop mode
// [R16] copies to blocked cpu queues are discarded
// [R17] a setting chooses whether discarded copies still make their mirror copy
// [R18] ingress queue heads picked by weighted round robin with per-port weight
// [R19] drop-mode copies may drop; flow-control frames stall at queue head
// [R20] drop counter steps by one per copy dropped at the copy limit; harsh and blocked-queue discards are not counted
`timescale 1ns/1ns
`include "frame_copy_forwarder_map.vh"

module frame_copy_forwarder (
    input wire CLOCK,
    input wire RST_N,
    input wire CE,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire [3:0] IQ_VALID,
    output wire [3:0] IQ_POP,
    input wire [31:0] IQ_SIZE,
    input wire [3:0] HEAD_DEST,
    input wire [7:0] HEAD_CPU_QUEUE_MASK,
    input wire [1:0] HEAD_MIRROR,
    input wire HEAD_LEARN,
    input wire HEAD_DROP,
    input wire [2:0] HEAD_QOS,
    input wire HEAD_FC,
    input wire HEAD_OVER_PAUSE,
    input wire [5:0] EGR_RESERVE_GONE,
    input wire [5:0] EGR_CONGESTED,
    output wire [1:0] HEAD_PORT,
    output reg [5:0] TX_REQ,
    output reg [23:0] TX_QOS,
    output reg [3:0] TX_SRC
);

    // ***********************************
    // configuration and status storage
    // ***********************************
    reg [15:0] port_mode_q [0:3];
    reg [7:0] watermark_q [0:3];
    reg [7:0] copy_table_q [0:11];
    reg [5:0] learn_cfg_q;
    reg [7:0] cpu_queue_mask_block_q;
    reg mirror_keep_q;
    reg [31:0] drop_count_q;
    reg harsh_q;
    reg [1:0] rr_port_q;
    reg [3:0] credit_q;

    wire [3:0] over_mark;
    wire [3:0] eligible;
    // one loop index per process, so no variable has two drivers
    integer k;
    integer j;
    integer r;

    // per port watermark compare and eligibility
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            // [R03] watermark compare
            assign over_mark[p] = IQ_SIZE[p*8 +: 8] > watermark_q[p];
            // [R15] forwarding enable
            assign eligible[p] = IQ_VALID[p] & port_mode_q[p][`FCF_PM_ENABLE];
        end
    endgenerate

    // ***********************************
    // weighted round robin selection
    // ***********************************
    reg [1:0] sel;
    reg found;
    reg [1:0] cand;
    // [R18] search from current port
    always @* begin
        sel = rr_port_q;
        found = 1'b0;
        cand = 2'h0;
        for (k = 0; k < 4; k = k + 1) begin
            cand = rr_port_q + k[1:0];
            if (!found && eligible[cand]) begin
                sel = cand;
                found = 1'b1;
            end
        end
    end
    assign HEAD_PORT = sel;

    // ***********************************
    // copy generation for the selected head
    // ***********************************
    reg [5:0] req;
    reg [23:0] qos;
    reg [5:0] mirror_req;
    reg [23:0] mirror_qos;
    reg [3:0] copy_cnt;
    reg [3:0] limit;
    reg [5:0] kept;
    reg [5:0] dropped;
    reg [3:0] drop_n;
    reg stall;
    reg drop_mode;
    reg [7:0] ent;
    always @* begin
        req = 6'h00;
        qos = 24'h000000;
        mirror_req = 6'h00;
        mirror_qos = 24'h000000;
        ent = 8'h00;
        // [R08] normal switched copies
        for (j = 0; j < 4; j = j + 1) begin
            if (HEAD_DEST[j] && port_mode_q[j][`FCF_PM_ENABLE]) begin
                req[j] = 1'b1;
                qos[j*4 +: 4] = {1'b0, HEAD_QOS};
            end
        end
        // [R09] cpu queues through table
        // [R10] entry picks cpu port or front port
        for (j = 0; j < `FCF_CPU_QUEUE_MASK_N; j = j + 1) begin
            ent = copy_table_q[j];
            // [R16] blocked queue dropped
            if (HEAD_CPU_QUEUE_MASK[j] && !cpu_queue_mask_block_q[j]) begin
                req[ent[2:0]] = 1'b1;
                // [R11] follow, fixed or super
                qos[ent[2:0]*4 +: 4] = ent[`FCF_CT_FOLLOW] ? {1'b0, HEAD_QOS} : ent[6:3];
            end
        end
        // [R12] mirror probes 1..3
        if (HEAD_MIRROR != 2'h0) begin
            ent = copy_table_q[`FCF_MIRROR_BASE + HEAD_MIRROR - 1];
            mirror_req[ent[2:0]] = 1'b1;
            mirror_qos[ent[2:0]*4 +: 4] = ent[6:3];
        end
        // [R13] learn copies to stack links
        if (HEAD_LEARN) begin
            ent = copy_table_q[`FCF_LEARN_ENTRY];
            if (ent[0]) begin
                req[2] = 1'b1;
            end
            if (ent[1]) begin
                req[3] = 1'b1;
            end
            // [R14] extra learn port
            if (learn_cfg_q[3]) begin
                req[learn_cfg_q[2:0]] = 1'b1;
            end
        end
        // [R19] drop mode from port or frame
        drop_mode = HEAD_DROP | port_mode_q[sel][`FCF_PM_DROP];
        // [R02] copy limit when above threshold
        limit = port_mode_q[sel][15:12];
        kept = 6'h00;
        dropped = 6'h00;
        copy_cnt = 4'h0;
        drop_n = 4'h0;
        stall = 1'b0;
        // copies are judged in egress port order, lowest port first
        for (j = 0; j < 6; j = j + 1) begin
            if (req[j]) begin
                // copies past the limit are lost and counted
                if (over_mark[sel] && copy_cnt >= limit) begin
                    dropped[j] = 1'b1;
                    drop_n = drop_n + 4'h1;
                end else if (harsh_q && port_mode_q[sel][`FCF_PM_HARSH] && !HEAD_FC &&
                             HEAD_OVER_PAUSE && EGR_RESERVE_GONE[j]) begin
                    // [R04] harsh discard, [R05] per port
                    dropped[j] = 1'b1;
                end else if (EGR_CONGESTED[j] && !drop_mode) begin
                    // flow control frame waits rather than lose a copy
                    stall = 1'b1;
                end else if (!EGR_CONGESTED[j]) begin
                    kept[j] = 1'b1;
                    copy_cnt = copy_cnt + 4'h1;
                end
            end
        end
    end

    // [R17] mirror kept unless every copy was discarded
    // a frame with only a mirror request has nothing dropped, so it mirrors;
    // a frame whose copies all died mirrors only when the keep setting is on
    wire mirror_ok = (|kept) | mirror_keep_q | ~(|dropped);
    wire take = found & !stall;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pop
            assign IQ_POP[p] = CE & take & (sel == p);
        end
    endgenerate

    // ***********************************
    // datapath and arbitration state
    // ***********************************
    // [R01] one head per cycle
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            TX_REQ <= 6'h00;
            TX_QOS <= 24'h000000;
            TX_SRC <= 4'h0;
            rr_port_q <= 2'h0;
            credit_q <= 4'h0;
            harsh_q <= 1'b0;
            drop_count_q <= 32'h00000000;
        end else if (CE) begin
            // [R03] chip-wide harsh state
            harsh_q <= |over_mark;
            TX_REQ <= take ? (kept | (mirror_ok ? mirror_req : 6'h00)) : 6'h00;
            // qos is zero when no head is taken; fields of dropped copies still carry their qos
            TX_QOS <= take ? (qos | (mirror_ok ? mirror_qos : 24'h000000)) : 24'h000000;
            TX_SRC <= take ? (4'h1 << sel) : 4'h0;
            // [R07] shared counter, [R20] one per copy over the limit
            if (take) begin
                drop_count_q <= drop_count_q + {28'h0000000, drop_n};
            end
            // [R18] stay for weight grants, then move on
            if (take && credit_q < port_mode_q[sel][11:8]) begin
                rr_port_q <= sel;
                credit_q <= credit_q + 4'h1;
            end else if (take) begin
                rr_port_q <= sel + 2'h1;
                credit_q <= 4'h0;
            end
        end
    end

    // ***********************************
    // register address decode
    // ***********************************
    // per-port registers come in groups of four words
    wire [1:0] addr_port = ADDR[1:0];
    wire hit_mode = (ADDR & `FCF_REG_GROUP_MASK) == `FCF_REG_PORT_MODE;
    wire hit_mark = (ADDR & `FCF_REG_GROUP_MASK) == `FCF_REG_WATERMARK;
    wire hit_size = (ADDR & `FCF_REG_GROUP_MASK) == `FCF_REG_IQ_STATUS;
    // copy table spans twelve words
    wire hit_table = (ADDR >= `FCF_REG_COPY_TABLE) && (ADDR < `FCF_REG_COPY_END);
    wire [3:0] table_idx = ADDR[3:0];
    // single registers
    wire hit_learn = ADDR == `FCF_REG_LEARN_CFG;
    wire hit_block = ADDR == `FCF_REG_CPU_QUEUE_MASK_BLOCK;
    wire hit_mirror = ADDR == `FCF_REG_MIRROR_CFG;
    wire hit_count = ADDR == `FCF_REG_DROP_COUNT;
    wire hit_state = ADDR == `FCF_REG_STATE;

    // ***********************************
    // register writes
    // ***********************************
    // read-only words (queue size, drop count, state) ignore writes
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            for (r = 0; r < 4; r = r + 1) begin
                port_mode_q[r] <= `FCF_PORT_MODE_RST;
                watermark_q[r] <= `FCF_WATERMARK_RST;
            end
            for (r = 0; r < `FCF_COPY_ENTRIES; r = r + 1) begin
                copy_table_q[r] <= `FCF_COPY_RST;
            end
            learn_cfg_q <= 6'h00;
            cpu_queue_mask_block_q <= 8'h00;
            mirror_keep_q <= 1'b0;
        end else if (CE && WR) begin
            // [R15] port mode write
            if (hit_mode) begin
                port_mode_q[addr_port] <= WDATA[15:0];
            end
            // [R02] watermark write
            if (hit_mark) begin
                watermark_q[addr_port] <= WDATA[7:0];
            end
            // [R09] copy table write
            if (hit_table) begin
                copy_table_q[table_idx] <= WDATA[7:0];
            end
            // [R14] learn extra port
            if (hit_learn) begin
                learn_cfg_q <= WDATA[5:0];
            end
            // [R16] cpu queue block mask
            if (hit_block) begin
                cpu_queue_mask_block_q <= WDATA[7:0];
            end
            // [R17] mirror keep setting
            if (hit_mirror) begin
                mirror_keep_q <= WDATA[0];
            end
        end
    end

    // ***********************************
    // register reads, one cycle later
    // ***********************************
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            RDATA <= 32'h00000000;
        end else if (CE) begin
            RDATA <= 32'h00000000;
            if (RD) begin
                if (hit_mode) begin
                    RDATA <= {16'h0000, port_mode_q[addr_port]};
                end else if (hit_mark) begin
                    RDATA <= {24'h000000, watermark_q[addr_port]};
                end else if (hit_size) begin
                    // [R06] ingress queue size
                    RDATA <= {24'h000000, IQ_SIZE[addr_port*8 +: 8]};
                end else if (hit_table) begin
                    RDATA <= {24'h000000, copy_table_q[table_idx]};
                end else if (hit_learn) begin
                    RDATA <= {26'h0000000, learn_cfg_q};
                end else if (hit_block) begin
                    RDATA <= {24'h000000, cpu_queue_mask_block_q};
                end else if (hit_mirror) begin
                    RDATA <= {31'h00000000, mirror_keep_q};
                end else if (hit_count) begin
                    // [R07] shared drop count
                    RDATA <= drop_count_q;
                end else if (hit_state) begin
                    // [R03] harsh state, port 0 mark and arbiter position
                    RDATA <= {27'h0000000, rr_port_q, over_mark[0], harsh_q, 1'b0};
                end
            end
        end
    end

endmodule

// ===== rtl/frame_copy_forwarder_map.vh
// register offsets, field positions, reset values and sizes of the frame copy forwarder
`ifndef FRAME_COPY_FORWARDER_MAP_VH
`define FRAME_COPY_FORWARDER_MAP_VH

// ***********************************
// sizes
// ***********************************
`define FCF_PORTS 4
`define FCF_PORT_W 2
`define FCF_EGR_PORTS 6
`define FCF_EGR_W 3
`define FCF_CPU_PORT0 3'h4
`define FCF_CPU_PORT1 3'h5
`define FCF_COPY_ENTRIES 12
`define FCF_CPU_QUEUE_MASK_N 8
`define FCF_MIRROR_BASE 8
`define FCF_LEARN_ENTRY 11
`define FCF_QOS_SUPER 4'h8
`define FCF_FRAME_RATE_MHZ 312
`define FCF_CLOCK_MHZ 25

// ***********************************
// register offsets (word index = address)
// ***********************************
`define FCF_REG_PORT_MODE 8'h00
`define FCF_REG_WATERMARK 8'h04
`define FCF_REG_IQ_STATUS 8'h08
`define FCF_REG_COPY_TABLE 8'h10
`define FCF_REG_LEARN_CFG 8'h20
`define FCF_REG_CPU_QUEUE_MASK_BLOCK 8'h21
`define FCF_REG_MIRROR_CFG 8'h22
`define FCF_REG_DROP_COUNT 8'h23
`define FCF_REG_STATE 8'h24
`define FCF_REG_COPY_END 8'h1C
`define FCF_REG_GROUP_MASK 8'hFC

// ***********************************
// port mode fields
// ***********************************
`define FCF_PM_ENABLE 0
`define FCF_PM_DROP 1
`define FCF_PM_HARSH 2
`define FCF_PM_SPEED_LO 4
`define FCF_PM_WEIGHT_LO 8
`define FCF_PM_LIMIT_LO 12
`define FCF_PORT_MODE_RST 16'h0001
`define FCF_WATERMARK_RST 8'hFF

// ***********************************
// copy table entry: [2:0] port, [6:3] qos, [7] follow ingress qos
// ***********************************
`define FCF_CT_FOLLOW 7
`define FCF_COPY_RST 8'h04

`endif

// ===== bench/frame_copy_forwarder_properties.sv
// port checks for the frame copy forwarder
`timescale 1ns/1ns
module fcf_checker (
    input wire CLOCK,
    input wire RST_N,
    input wire CE,
    input wire RD,
    input wire [31:0] RDATA,
    input wire [3:0] IQ_VALID,
    input wire [3:0] IQ_POP,
    input wire [3:0] HEAD_DEST,
    input wire [7:0] HEAD_CPU_QUEUE_MASK,
    input wire [1:0] HEAD_MIRROR,
    input wire HEAD_LEARN,
    input wire HEAD_DROP,
    input wire [5:0] EGR_CONGESTED,
    input wire [1:0] HEAD_PORT,
    input wire [5:0] TX_REQ,
    input wire [3:0] TX_SRC
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    property p_read_slot;
        CE && !$past(RD) |-> RDATA == 32'h0;
    endproperty
    a_read_slot: assert property (p_read_slot) else $error("read data off slot");
    property p_pop_single;
        $onehot0(IQ_POP) && (IQ_POP & ~IQ_VALID) == 4'h0;
    endproperty
    a_pop_single: assert property (p_pop_single) else $error("bad head take");
    property p_pop_port;
        IQ_POP != 4'h0 |-> IQ_POP == (4'h1 << HEAD_PORT);
    endproperty
    a_pop_port: assert property (p_pop_port) else $error("take off shown port");
    property p_tx_cause;
        CE && IQ_POP == 4'h0 |=> TX_REQ == 6'h0 && TX_SRC == 4'h0;
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("request without take");
    property p_tx_src;
        CE && IQ_POP != 4'h0 |=> TX_REQ == 6'h0 || TX_SRC == $past(IQ_POP);
    endproperty
    a_tx_src: assert property (p_tx_src) else $error("wrong source port");
    property p_front_only;
        CE && IQ_POP != 4'h0 && HEAD_CPU_QUEUE_MASK == 8'h0 && HEAD_MIRROR == 2'h0 && !HEAD_LEARN
            |=> (TX_REQ & ~{2'b00, $past(HEAD_DEST)}) == 6'h0;
    endproperty
    a_front_only: assert property (p_front_only) else $error("copy outside set");
    property p_fc_stall;
        IQ_VALID[HEAD_PORT] && !HEAD_DROP && (HEAD_DEST & EGR_CONGESTED[3:0]) != 4'h0
            |-> IQ_POP == 4'h0;
    endproperty
    a_fc_stall: assert property (p_fc_stall) else $error("stalled head taken");
    property p_drop_copy;
        CE && IQ_POP != 4'h0 && HEAD_DROP
            |=> (TX_REQ[3:0] & $past(EGR_CONGESTED[3:0]) & $past(HEAD_DEST)) == 4'h0;
    endproperty
    a_drop_copy: assert property (p_drop_copy) else $error("congested copy sent");
endmodule

// ===== bench/fcf_head_source.sv
// ingress queue heads as the analyzer presents them
`timescale 1ns/1ns
module fcf_head_source (
    input wire CLOCK,
    input wire RST_N,
    input wire load,
    input wire [1:0] load_port,
    input wire [20:0] load_head,
    input wire [3:0] IQ_POP,
    input wire [1:0] HEAD_PORT,
    output wire [3:0] IQ_VALID,
    output wire [20:0] head_bus
);
    reg [20:0] head_q [0:3];
    reg [20:0] last_q;
    reg [3:0] valid_q;
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            valid_q <= 4'h0;
            last_q <= 21'h0;
        end else begin
            valid_q <= (valid_q & ~IQ_POP) | ({3'h0, load} << load_port);
            last_q <= head_bus;
            if (load) begin
                head_q[load_port] <= load_head;
            end
        end
    end
    // empty port shows a scrambled head
    assign IQ_VALID = valid_q;
    assign head_bus = valid_q[HEAD_PORT] ? head_q[HEAD_PORT] : ~last_q;
endmodule

// ===== bench/frame_copy_forwarder_bench.sv
// self-checking bench of the frame copy forwarder
`timescale 1ns/1ns
`include "frame_copy_forwarder_map.vh"
module frame_copy_forwarder_bench;
    reg CLOCK, RST_N, WR, RD, load;
    reg [7:0] ADDR;
    reg [31:0] WDATA, IQ_SIZE, seed, rv;
    reg [5:0] EGR_RESERVE_GONE, EGR_CONGESTED, last_tx;
    reg [1:0] load_port;
    reg [20:0] load_head;
    wire [31:0] RDATA;
    wire [3:0] IQ_VALID, IQ_POP, TX_SRC;
    wire [20:0] hb;
    wire [1:0] HEAD_PORT;
    wire [5:0] TX_REQ;
    wire [23:0] TX_QOS;
    integer error_cnt, checks, cyc, i, k, n;
    // ********
    // harness
    // ********
    frame_copy_forwarder dut (.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IQ_VALID(IQ_VALID), .IQ_POP(IQ_POP),
        .IQ_SIZE(IQ_SIZE), .HEAD_DEST(hb[3:0]), .HEAD_CPU_QUEUE_MASK(hb[11:4]), .HEAD_MIRROR(hb[13:12]),
        .HEAD_LEARN(hb[14]), .HEAD_QOS(hb[17:15]), .HEAD_OVER_PAUSE(hb[18]), .HEAD_FC(hb[19]),
        .HEAD_DROP(hb[20]), .EGR_RESERVE_GONE(EGR_RESERVE_GONE), .EGR_CONGESTED(EGR_CONGESTED),
        .HEAD_PORT(HEAD_PORT), .TX_REQ(TX_REQ), .TX_QOS(TX_QOS), .TX_SRC(TX_SRC));
    fcf_head_source src (.CLOCK(CLOCK), .RST_N(RST_N), .load(load), .load_port(load_port),
        .load_head(load_head), .IQ_POP(IQ_POP), .HEAD_PORT(HEAD_PORT), .IQ_VALID(IQ_VALID),
        .head_bus(hb));
    // clock
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    // cycle ceiling against hangs
    always @(posedge CLOCK) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input string what, input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask
    task rdchk(input [7:0] a, input [31:0] m, input [31:0] exp);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        check("rdata", RDATA & m, exp);
        @(posedge CLOCK);
    endtask
    task put(input [1:0] p, input [20:0] h);
        load_port <= p;
        load_head <= h;
        load <= 1'b1;
        @(posedge CLOCK);
        load <= 1'b0;
    endtask
    // exp of all ones skips the request compare
    task take(input [5:0] exp, input [23:0] qm, input [23:0] qx);
        for (n = 0; n < 40 && IQ_POP === 4'h0; n = n + 1) @(negedge CLOCK);
        @(negedge CLOCK);
        last_tx = TX_REQ;
        if (exp !== 6'h3F) check("tx_req", {26'h0, TX_REQ}, {26'h0, exp});
        check("tx_qos", {8'h0, TX_QOS & qm}, {8'h0, qx});
        @(posedge CLOCK);
    endtask
    task frame(input [1:0] p, input [20:0] h, input [5:0] exp, input [23:0] qm, input [23:0] qx);
        put(p, h);
        take(exp, qm, qx);
    endtask
    // main sequence
    initial begin
        error_cnt = 0;
        checks = 0;
        cyc = 0;
        seed = 32'h31285199;
        {RST_N, WR, RD, load, ADDR, WDATA, load_port, load_head} = 0;
        {IQ_SIZE, EGR_RESERVE_GONE, EGR_CONGESTED} = 0;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        rdchk(`FCF_REG_PORT_MODE, 32'hFFFFFFFF, 32'h1);
        rdchk(`FCF_REG_WATERMARK, 32'hFFFFFFFF, 32'hFF);
        rdchk(`FCF_REG_COPY_TABLE, 32'hFFFFFFFF, 32'h4);
        rdchk(8'h30, 32'hFFFFFFFF, 32'h0);
        wr(`FCF_REG_DROP_COUNT, 32'h5);
        for (i = 0; i < 24; i = i + 1) begin
            rv = $random(seed);
            IQ_SIZE <= rv & 32'hFEFEFEFE;
            frame(rv[9:8], {17'h0, rv[3:0] | 4'h1}, {2'h0, rv[3:0] | 4'h1}, 0, 0);
            rdchk(8'h08 + rv[9:8], 32'hFF, (IQ_SIZE >> {rv[9:8], 3'h0}) & 32'hFF);
        end
        for (i = 0; i < 8; i = i + 1) begin
            k = i[2] ? 4 + i[0] : i[1:0];
            wr(8'h10 + i[7:0], {25'h0, i[3:0], k[2:0]});
            frame(2'h2, {9'h0, 8'h1 << i, 4'h0}, 6'h1 << k, 24'hF << 4 * k, 24'(i) << 4 * k);
        end
        wr(8'h15, 32'h85);
        frame(2'h1, {3'h0, 3'h6, 3'h0, 8'h20, 4'h0}, 6'h20, 24'hF00000, 24'h600000);
        wr(8'h16, 32'h45);
        frame(2'h1, {9'h0, 8'h40, 4'h0}, 6'h20, 24'hF00000, 24'h800000);
        wr(`FCF_REG_CPU_QUEUE_MASK_BLOCK, 32'h40);
        frame(2'h1, {9'h0, 8'h40, 4'h0}, 6'h0, 0, 0);
        for (i = 1; i < 4; i = i + 1) begin
            wr(8'h17 + i[7:0], {25'h0, i[3:0], i[2:0]});
            frame(2'h0, {7'h0, i[1:0], 12'h0}, 6'h1 << i, 24'hF << 4 * i, 24'(i) << 4 * i);
        end
        for (i = 1; i < 4; i = i + 1) begin
            wr(8'h1B, i);
            frame(2'h3, {6'h0, 1'b1, 14'h0}, {2'h0, i[1:0], 2'h0}, 0, 0);
        end
        wr(`FCF_REG_LEARN_CFG, 32'hC);
        frame(2'h3, {6'h0, 1'b1, 14'h0}, 6'h1C, 0, 0);
        IQ_SIZE <= 32'h0303;
        for (i = 0; i < 2; i = i + 1) begin
            wr(8'h04 + i[7:0], 32'h2);
            wr(8'h00 + i[7:0], 32'h1001);
            frame(i[1:0], 21'hF, 6'h3F, 0, 0);
            check("copies", $countones(last_tx), 1);
        end
        rdchk(`FCF_REG_DROP_COUNT, 32'hFFFFFFFF, 32'h6);
        rdchk(`FCF_REG_STATE, 32'h6, 32'h6);
        EGR_RESERVE_GONE <= 6'h2;
        wr(8'h02, 32'h5);
        frame(2'h2, {3'h1, 14'h0, 4'hB}, 6'h09, 0, 0);
        frame(2'h2, {3'h3, 14'h0, 4'hB}, 6'h0B, 0, 0);
        wr(8'h02, 32'h1);
        frame(2'h2, {3'h1, 14'h0, 4'hB}, 6'h0B, 0, 0);
        EGR_RESERVE_GONE <= 6'h0;
        EGR_CONGESTED <= 6'h2;
        frame(2'h3, {3'h4, 14'h0, 4'h3}, 6'h01, 0, 0);
        put(2'h3, {17'h0, 4'h3});
        repeat (6) @(negedge CLOCK);
        check("held", {31'h0, IQ_VALID[3]}, 32'h1);
        @(posedge CLOCK);
        EGR_CONGESTED <= 6'h0;
        take(6'h03, 0, 0);
        report_and_stop;
    end
endmodule
bind frame_copy_forwarder fcf_checker chk (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .RD(RD),
    .RDATA(RDATA), .IQ_VALID(IQ_VALID), .IQ_POP(IQ_POP), .HEAD_DEST(HEAD_DEST),
    .HEAD_CPU_QUEUE_MASK(HEAD_CPU_QUEUE_MASK), .HEAD_MIRROR(HEAD_MIRROR), .HEAD_LEARN(HEAD_LEARN),
    .HEAD_DROP(HEAD_DROP), .EGR_CONGESTED(EGR_CONGESTED), .HEAD_PORT(HEAD_PORT),
    .TX_REQ(TX_REQ), .TX_SRC(TX_SRC));
